/* File: rtl/hlog_pkg.sv */
// package for the health and firmware slot log page generator
package hlog_pkg;
    localparam int unsigned PAGE_BYTES     = 512;
    localparam logic [8:0]  PAGE_LAST      = 9'h1_FF;
    // health page field starts (16-byte counters)
    localparam logic [8:0]  OFS_WR_CMDS    = 9'h0_50;
    localparam logic [8:0]  OFS_BUSY       = 9'h0_60;
    localparam logic [8:0]  OFS_PWR_CYC    = 9'h0_70;
    localparam logic [8:0]  OFS_PON_HRS    = 9'h0_80;
    localparam logic [8:0]  OFS_UNSAFE     = 9'h0_90;
    localparam logic [8:0]  OFS_MEDIA      = 9'h0_A0;
    localparam logic [8:0]  OFS_ERRLOG     = 9'h0_B0;
    localparam logic [8:0]  OFS_HLTH_END   = 9'h0_C0;
    // firmware slot page layout
    localparam logic [8:0]  OFS_ACT_SLOT   = 9'h0_00;
    localparam logic [8:0]  OFS_SLOT1      = 9'h0_08;
    localparam logic [8:0]  OFS_SLOT_END   = 9'h0_40;
    localparam logic [7:0]  ACT_SLOT_MASK  = 8'h07;
    // log identifiers and status codes
    localparam logic [7:0]  LID_HEALTH     = 8'h02;
    localparam logic [7:0]  LID_FW_SLOT    = 8'h03;
    localparam logic [7:0]  SC_SUCCESS     = 8'h00;
    localparam logic [7:0]  SC_INVALID_LOG = 8'h09;
    // busy time unit: minutes
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned BUSY_UNIT_MIN  = 1;
    localparam longint unsigned BUSY_UNIT_CYC = 64'(BUSY_UNIT_MIN) * 60 * CLK_MHZ * 1000000;
    localparam int unsigned PON_UNIT_HRS   = 1;
    localparam longint unsigned PON_UNIT_CYC  = 64'(PON_UNIT_HRS) * 3600 * CLK_MHZ * 1000000;

    typedef struct packed {
        logic       valid;   // request strobe
        logic [7:0] lid;     // log identifier
        logic [31:0] nsid;   // namespace named by the request, ignored
    } hlog_req_t;

    typedef struct packed {
        logic       valid;   // completion post strobe
        logic [7:0] status;  // command specific status
    } hlog_cpl_t;

    typedef struct packed {
        logic       valid;   // data byte valid
        logic [8:0] addr;    // byte offset within page
        logic [7:0] data;    // byte value
    } hlog_beat_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_WAIT = 2'b11,
        ST_CPL  = 2'b10
    } hlog_state_t;
endpackage

/* File: rtl/hlog_pages.sv */
// health (upper counters) and firmware slot log page generator
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module hlog_pages
(
    input  wire logic                 mclk_i,          // 125 MHz clock
    input  wire logic                 nrst_i,          // async reset, active low
    input  wire hlog_pkg::hlog_req_t  req_i,           // log page request
    input  wire logic                 xfer_ready_i,    // host buffer accepts byte
    input  wire logic                 wr_cmd_done_i,   // write command completed pulse
    input  wire logic                 io_outstanding_i,// any io queue command open
    input  wire logic                 power_up_i,      // power cycle event pulse
    input  wire logic                 low_power_i,     // in low power state
    input  wire logic                 power_loss_i,    // power loss event pulse
    input  wire logic                 shutdown_notify_field_i, // shutdown notified
    input  wire logic                 media_err_i,     // unrecovered integrity error pulse
    input  wire logic                 err_log_entry_i, // error log entry created pulse
    input  wire logic [2:0]           active_slot_info_i, // running slot number
    input  wire logic [6:0]           slot_valid_i,    // slot holds valid revision
    input  wire logic [447:0]         slot_rev_i,      // slot one..seven revisions, 64b each
    output logic                      busy_o,          // request in progress
    output hlog_pkg::hlog_beat_t      beat_o,          // page byte to host buffer
    output hlog_pkg::hlog_cpl_t       cpl_o            // completion post
);
    ////////////////////////////////////////////////////////////////////////////
    // counters
    logic [127:0] wr_cnt_q, wr_cnt_d;
    logic [127:0] busy_cnt_q, busy_cnt_d;
    logic [127:0] pcyc_cnt_q, pcyc_cnt_d;
    logic [127:0] pon_cnt_q, pon_cnt_d;
    logic [127:0] unsafe_cnt_q, unsafe_cnt_d;
    logic [127:0] media_cnt_q, media_cnt_d;
    logic [127:0] errlog_cnt_q, errlog_cnt_d;
    logic [39:0]  busy_tick_q, busy_tick_d;
    logic [43:0]  pon_tick_q, pon_tick_d;
    logic         notify_seen_q, notify_seen_d;
    logic [6:0]   slot_vld_s1_q, slot_vld_s2_q;

    function automatic logic [127:0] inc_cnt(input logic [127:0] c, input logic ev);
        inc_cnt = (ev && c != {128{1'b1}}) ? c + 128'd1 : c;
    endfunction

    always_comb
    begin
        wr_cnt_d     = inc_cnt(wr_cnt_q, wr_cmd_done_i);
        pcyc_cnt_d   = inc_cnt(pcyc_cnt_q, power_up_i);
        media_cnt_d  = inc_cnt(media_cnt_q, media_err_i);
        errlog_cnt_d = inc_cnt(errlog_cnt_q, err_log_entry_i);
        // notification seen before loss makes the loss safe
        unsafe_cnt_d = inc_cnt(unsafe_cnt_q, power_loss_i && !notify_seen_q);
        // a notice in the power-up cycle itself is kept: set wins over clear
        notify_seen_d = (notify_seen_q && !power_up_i) || shutdown_notify_field_i;
        busy_tick_d  = busy_tick_q;
        busy_cnt_d   = busy_cnt_q;
        if (io_outstanding_i)
        begin
            if (busy_tick_q == 40'(hlog_pkg::BUSY_UNIT_CYC - 1))
            begin
                busy_tick_d = '0;
                busy_cnt_d  = inc_cnt(busy_cnt_q, 1'b1);
            end
            else
                busy_tick_d = busy_tick_q + 40'd1;
        end
        pon_tick_d = pon_tick_q;
        pon_cnt_d  = pon_cnt_q;
        if (!low_power_i)
        begin
            if (pon_tick_q == 44'(hlog_pkg::PON_UNIT_CYC - 1))
            begin
                pon_tick_d = '0;
                pon_cnt_d  = inc_cnt(pon_cnt_q, 1'b1);
            end
            else
                pon_tick_d = pon_tick_q + 44'd1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_cnt_q      <= '0;
            busy_cnt_q    <= '0;
            pcyc_cnt_q    <= '0;
            pon_cnt_q     <= '0;
            unsafe_cnt_q  <= '0;
            media_cnt_q   <= '0;
            errlog_cnt_q  <= '0;
            busy_tick_q   <= '0;
            pon_tick_q    <= '0;
            notify_seen_q <= 1'b0;
            slot_vld_s1_q <= '0;
            slot_vld_s2_q <= '0;
        end
        else
        begin
            wr_cnt_q      <= wr_cnt_d;
            busy_cnt_q    <= busy_cnt_d;
            pcyc_cnt_q    <= pcyc_cnt_d;
            pon_cnt_q     <= pon_cnt_d;
            unsafe_cnt_q  <= unsafe_cnt_d;
            media_cnt_q   <= media_cnt_d;
            errlog_cnt_q  <= errlog_cnt_d;
            busy_tick_q   <= busy_tick_d;
            pon_tick_q    <= pon_tick_d;
            notify_seen_q <= notify_seen_d;
            // slot status comes from firmware store, a separate domain
            slot_vld_s1_q <= slot_valid_i;
            slot_vld_s2_q <= slot_vld_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // page byte selection
    function automatic logic [7:0] cnt_byte(input logic [127:0] c, input logic [8:0] a, input logic [8:0] base);
        logic [8:0] rel;
        rel = a - base;
        cnt_byte = c[rel[3:0]*8 +: 8];
    endfunction

    function automatic logic [7:0] page_byte(input logic fw, input logic [8:0] a);
        logic [8:0] rel;
        logic [2:0] slot;
        page_byte = 8'h00;
        rel       = a - hlog_pkg::OFS_SLOT1;
        slot      = rel[5:3];
        if (fw)
        begin
            // namespace never consulted for this page
            if (a == hlog_pkg::OFS_ACT_SLOT)
                page_byte = {5'b0_0000, active_slot_info_i} & hlog_pkg::ACT_SLOT_MASK;
            else if (a >= hlog_pkg::OFS_SLOT1 && a < hlog_pkg::OFS_SLOT_END)
                page_byte = slot_vld_s2_q[slot] ? slot_rev_i[{slot, rel[2:0]}*8 +: 8] : 8'h00;
        end
        else if (a >= hlog_pkg::OFS_ERRLOG && a < hlog_pkg::OFS_HLTH_END)
            page_byte = cnt_byte(errlog_cnt_q, a, hlog_pkg::OFS_ERRLOG);
        else if (a >= hlog_pkg::OFS_MEDIA && a < hlog_pkg::OFS_ERRLOG)
            page_byte = cnt_byte(media_cnt_q, a, hlog_pkg::OFS_MEDIA);
        else if (a >= hlog_pkg::OFS_UNSAFE && a < hlog_pkg::OFS_MEDIA)
            page_byte = cnt_byte(unsafe_cnt_q, a, hlog_pkg::OFS_UNSAFE);
        else if (a >= hlog_pkg::OFS_PON_HRS && a < hlog_pkg::OFS_UNSAFE)
            page_byte = cnt_byte(pon_cnt_q, a, hlog_pkg::OFS_PON_HRS);
        else if (a >= hlog_pkg::OFS_PWR_CYC && a < hlog_pkg::OFS_PON_HRS)
            page_byte = cnt_byte(pcyc_cnt_q, a, hlog_pkg::OFS_PWR_CYC);
        else if (a >= hlog_pkg::OFS_BUSY && a < hlog_pkg::OFS_PWR_CYC)
            page_byte = cnt_byte(busy_cnt_q, a, hlog_pkg::OFS_BUSY);
        else if (a >= hlog_pkg::OFS_WR_CMDS && a < hlog_pkg::OFS_BUSY)
            page_byte = cnt_byte(wr_cnt_q, a, hlog_pkg::OFS_WR_CMDS);
        // lower health counters live in another block; they read zero here
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // request sequencer
    hlog_pkg::hlog_state_t st_q, st_d;
    logic [8:0]            addr_q, addr_d;
    logic                  fw_q, fw_d;
    logic                  busy_q, busy_d;
    hlog_pkg::hlog_beat_t  beat_q, beat_d;
    hlog_pkg::hlog_cpl_t   cpl_q, cpl_d;

    always_comb
    begin
        st_d          = st_q;
        addr_d        = addr_q;
        fw_d          = fw_q;
        busy_d        = busy_q;
        beat_d        = beat_q;
        cpl_d         = '0;
        case (st_q)
            hlog_pkg::ST_IDLE:
            begin
                beat_d = '0;
                if (req_i.valid)
                begin
                    busy_d = 1'b1;
                    addr_d = '0;
                    if (req_i.lid == hlog_pkg::LID_FW_SLOT)
                    begin
                        fw_d = 1'b1;
                        st_d = hlog_pkg::ST_XFER;
                    end
                    else if (req_i.lid == hlog_pkg::LID_HEALTH)
                    begin
                        fw_d = 1'b0;
                        st_d = hlog_pkg::ST_XFER;
                    end
                    else
                    begin
                        cpl_d.valid  = 1'b1;
                        cpl_d.status = hlog_pkg::SC_INVALID_LOG;
                        st_d         = hlog_pkg::ST_CPL;
                    end
                end
            end
            hlog_pkg::ST_XFER:
            begin
                if (!beat_q.valid || xfer_ready_i)
                begin
                    beat_d.valid = 1'b1;
                    beat_d.addr  = addr_q;
                    beat_d.data  = page_byte(fw_q, addr_q);
                    addr_d       = addr_q + 9'd1;
                    if (addr_q == hlog_pkg::PAGE_LAST)
                        st_d = hlog_pkg::ST_WAIT;
                end
            end
            hlog_pkg::ST_WAIT:
            begin
                if (xfer_ready_i)
                begin
                    beat_d      = '0;
                    cpl_d.valid  = 1'b1;
                    cpl_d.status = hlog_pkg::SC_SUCCESS;
                    st_d         = hlog_pkg::ST_CPL;
                end
            end
            hlog_pkg::ST_CPL:
            begin
                busy_d = 1'b0;
                st_d   = hlog_pkg::ST_IDLE;
            end
            default:
                st_d = hlog_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_q   <= hlog_pkg::ST_IDLE;
            addr_q <= '0;
            fw_q   <= 1'b0;
            busy_q <= 1'b0;
            beat_q <= '0;
            cpl_q  <= '0;
        end
        else
        begin
            st_q   <= st_d;
            addr_q <= addr_d;
            fw_q   <= fw_d;
            busy_q <= busy_d;
            beat_q <= beat_d;
            cpl_q  <= cpl_d;
        end
    end

    assign busy_o = busy_q;
    assign beat_o = beat_q;
    assign cpl_o  = cpl_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_wr_count_step: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr_cmd_done_i && wr_cnt_q != {128{1'b1}} |=> wr_cnt_q == $past(wr_cnt_q) + 128'd1)
        else $error("write command count did not step");
    a_busy_idle_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !io_outstanding_i |=> busy_cnt_q == $past(busy_cnt_q) && busy_tick_q == $past(busy_tick_q))
        else $error("busy time moved while idle");
    a_pcyc_count: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !power_up_i |=> pcyc_cnt_q == $past(pcyc_cnt_q))
        else $error("power cycle count moved without event");
    a_pon_lowpwr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        low_power_i |=> pon_tick_q == $past(pon_tick_q))
        else $error("power on time advanced in low power");
    a_unsafe_safe: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        power_loss_i && notify_seen_q |=> unsafe_cnt_q == $past(unsafe_cnt_q))
        else $error("notified shutdown counted as unsafe");
    a_media_step: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        media_err_i && media_cnt_q != {128{1'b1}} |=> media_cnt_q == $past(media_cnt_q) + 128'd1)
        else $error("media error not counted");
    a_errlog_step: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        err_log_entry_i && errlog_cnt_q != {128{1'b1}} |=> errlog_cnt_q == $past(errlog_cnt_q) + 128'd1)
        else $error("error log entry not counted");
    a_bad_lid_status: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        st_q == hlog_pkg::ST_IDLE && req_i.valid && req_i.lid != hlog_pkg::LID_FW_SLOT
        && req_i.lid != hlog_pkg::LID_HEALTH |=> cpl_q.valid && cpl_q.status == hlog_pkg::SC_INVALID_LOG)
        else $error("invalid log id not refused with 9h");
    a_cpl_after_last: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        cpl_q.valid && cpl_q.status == hlog_pkg::SC_SUCCESS |-> $past(beat_q.valid && xfer_ready_i)
        && $past(beat_q.addr) == hlog_pkg::PAGE_LAST)
        else $error("completion before whole page moved");
    a_act_slot_rsvd: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        beat_q.valid && fw_q && beat_q.addr == hlog_pkg::OFS_ACT_SLOT |-> beat_q.data[7:3] == 5'b0_0000)
        else $error("active slot byte reserved bits set");
    a_fw_tail_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        beat_q.valid && fw_q && beat_q.addr >= hlog_pkg::OFS_SLOT_END |-> beat_q.data == 8'h00)
        else $error("reserved firmware page byte nonzero");
endmodule // hlog_pages
`default_nettype wire

/* File: sim/hlog_host_model.sv */
// host buffer model: takes page bytes from the block, stalling at random on request
`timescale 1ns/10ps
`default_nettype none
module hlog_host_model
(
    input  wire logic                 mclk_i,       // clock
    input  wire logic                 nrst_i,       // async reset, active low
    input  wire hlog_pkg::hlog_beat_t beat_i,       // byte offered by the block
    input  wire logic                 slow_i,       // stall at random when high
    output logic                      xfer_ready_o, // buffer takes the byte
    output logic                      ord_err_o,    // byte seen out of order
    output int unsigned               count_o,      // bytes taken so far
    output logic [7:0]                page_o [512]  // last page written
);
    logic [15:0] lfsr_q;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            lfsr_q       <= 16'hace1;
            xfer_ready_o <= 1'b0;
            ord_err_o    <= 1'b0;
            count_o      <= 0;
        end
        else
        begin
            lfsr_q       <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            // ready changes only after an edge, so a stalled byte must stand
            xfer_ready_o <= slow_i ? lfsr_q[0] : 1'b1;
            if (beat_i.valid && xfer_ready_o)
            begin
                page_o[beat_i.addr] <= beat_i.data;
                count_o             <= count_o + 1;
                if (beat_i.addr !== count_o[8:0]) ord_err_o <= 1'b1;
            end
        end
    end
endmodule // hlog_host_model
`default_nettype wire

/* File: sim/tb_hlog_pages.sv */
// self-checking bench for the health and firmware slot log page generator
`timescale 1ns/10ps
`default_nettype none
module tb_hlog_pages;
    logic                 mclk_i, nrst_i, xfer_ready_i, wr_cmd_done_i, io_outstanding_i, power_up_i;
    logic                 low_power_i, power_loss_i, shutdown_notify_field_i, media_err_i, err_log_entry_i;
    logic [2:0]           active_slot_info_i;
    logic [6:0]           slot_valid_i;
    logic [447:0]         slot_rev_i;
    logic                 busy_o, slow, ord_err, notified;
    hlog_pkg::hlog_req_t  req_i;
    hlog_pkg::hlog_beat_t beat_o;
    hlog_pkg::hlog_cpl_t  cpl_o;
    int unsigned          count, ev [7];
    logic [7:0]           page [512];
    logic [7:0]           bad_lid [6];
    logic [31:0]          seed, r;
    int                   fails, samples_checked, cycles;
    hlog_pages hlog_pages_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i), .xfer_ready_i(xfer_ready_i),
        .wr_cmd_done_i(wr_cmd_done_i), .io_outstanding_i(io_outstanding_i), .power_up_i(power_up_i),
        .low_power_i(low_power_i), .power_loss_i(power_loss_i), .shutdown_notify_field_i(shutdown_notify_field_i),
        .media_err_i(media_err_i), .err_log_entry_i(err_log_entry_i), .active_slot_info_i(active_slot_info_i),
        .slot_valid_i(slot_valid_i), .slot_rev_i(slot_rev_i), .busy_o(busy_o), .beat_o(beat_o), .cpl_o(cpl_o));
    hlog_host_model hlog_host_model_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .beat_i(beat_o), .slow_i(slow),
        .xfer_ready_o(xfer_ready_i), .ord_err_o(ord_err), .count_o(count), .page_o(page));
    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // counters are 16 bytes wide but the bench counts stay far below 2^32
    function automatic logic [7:0] exp_byte(input logic [7:0] lid, input int a);
        if (lid == 8'h03)
        begin
            if (a == 0) return {5'h00, active_slot_info_i};
            if (a < 8 || a > 63) return 8'h00;
            return slot_valid_i[(a - 8) / 8] ? slot_rev_i[(a - 8) * 8 +: 8] : 8'h00;
        end
        if (a < 80 || a > 191 || (a - 80) % 16 > 3) return 8'h00;
        return 8'(ev[(a - 80) / 16] >> (8 * ((a - 80) % 16)));
    endfunction
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_req(input logic [7:0] lid, input logic [31:0] nsid, input logic dup);
        int unsigned c0;
        int          n;
        logic        good;
        good = (lid == 8'h02) || (lid == 8'h03);
        c0 = count;
        n = 0;
        @(posedge mclk_i);
        req_i <= '{valid: 1'b1, lid: lid, nsid: nsid};
        do
        begin
            @(posedge mclk_i);
            req_i.valid <= dup && n == 6; // a second request while busy must be ignored
            #1;
            n++;
        end
        while (cpl_o.valid !== 1'b1 && n < 4000);
        chk("cpl status", good ? 64'h0 : 64'h9, cpl_o.status);
        chk("bytes moved", good ? 512 : 0, count - c0);
        chk("beat at cpl", 0, beat_o.valid);
        chk("busy at cpl", 1, busy_o);
        if (!good) chk("refusal latency", 1, n);
        @(posedge mclk_i);
        #1;
        chk("busy after cpl", 0, busy_o);
        chk("cpl pulse", 0, cpl_o.valid);
        chk("byte order", 0, ord_err);
        if (good)
            for (int i = 0; i < 512; i++)
                chk($sformatf("page %h byte %0d", lid, i), exp_byte(lid, i), page[i]);
    endtask
    task automatic run_events(input int n);
        repeat (n)
        begin
            @(posedge mclk_i);
            r = xs();
            wr_cmd_done_i           <= r[0];
            media_err_i             <= r[1];
            err_log_entry_i         <= r[2];
            io_outstanding_i        <= r[3];
            low_power_i             <= r[4];
            power_up_i              <= r[7:5] == 3'd1;
            power_loss_i            <= r[7:5] == 3'd2;
            shutdown_notify_field_i <= r[7:5] == 3'd3;
            ev[0] += r[0];
            ev[5] += r[1];
            ev[6] += r[2];
            if (r[7:5] == 3'd1) ev[2]++;
            if (r[7:5] == 3'd2 && !notified) ev[4]++;
            if (r[7:5] == 3'd1 || r[7:5] == 3'd3) notified = r[7:5] == 3'd3;
        end
        @(posedge mclk_i);
        {wr_cmd_done_i, media_err_i, err_log_entry_i, power_up_i, power_loss_i, shutdown_notify_field_i} <= '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            finish_test();
        end
    end
    initial
    begin
        seed = 32'he994_7e32;
        {fails, samples_checked, cycles} = '0;
        {wr_cmd_done_i, io_outstanding_i, power_up_i, low_power_i, power_loss_i} = '0;
        {shutdown_notify_field_i, media_err_i, err_log_entry_i, slow, notified} = '0;
        {active_slot_info_i, slot_valid_i, slot_rev_i, req_i} = '0;
        ev = '{default: 0};
        nrst_i = 1'b0;
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        do_req(8'h02, 32'h0000_0000, 1'b0);
        run_events(400);
        slow = 1'b1;
        do_req(8'h02, xs(), 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk_i);
            r = xs();
            active_slot_info_i <= r[2:0];
            slot_valid_i       <= (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : r[9:3];
            for (int j = 0; j < 14; j++) slot_rev_i[32 * j +: 32] <= xs();
            repeat (3) @(posedge mclk_i);
            do_req(8'h03, xs(), i == 2);
        end
        r = xs();
        bad_lid = '{8'h00, 8'h01, 8'h04, 8'h7f, 8'hff, {1'b1, r[6:0]}};
        foreach (bad_lid[k])
            do_req(bad_lid[k], xs(), 1'b0);
        run_events(200);
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        ev = '{default: 0};
        notified = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        chk("busy in reset", 0, busy_o);
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        do_req(8'h02, xs(), 1'b0);
        finish_test();
    end
endmodule // tb_hlog_pages
`default_nettype wire
